// ---- ddrp_ctl_model.sv ----
// Memory controller model that drives the pins of the SRAM port
`timescale 1ns/1ps

module ddrp_ctl_model #(
   parameter int ADDR_W = 4,
   parameter int HALF   = 6
) (
   input  wire logic                 core_clk,
   input  wire logic                 single_mode,
   output logic                      k,
   output logic                      k_n,
   output logic                      c,
   output logic                      c_n,
   output logic                      cmd_n,
   output logic                      rw,
   output logic [ADDR_W-1:0]         a,
   output ddrp_pkg::ddrp_mask_t      mask_n,
   output ddrp_pkg::ddrp_word_t      d,
   input  wire ddrp_pkg::ddrp_word_t q,
   input  wire logic                 q_oe
);
   logic                 drv;
   logic                 moved;
   logic                 oe_k;
   logic                 oe_kn;
   ddrp_pkg::ddrp_word_t d_val;
   ddrp_pkg::ddrp_word_t junk;
   ddrp_pkg::ddrp_word_t q_k;
   ddrp_pkg::ddrp_word_t q_kn;

   // Output clocks parked high select single clock mode
   assign c   = single_mode | k;
   assign c_n = single_mode | k_n;
   // Released bus shows a moving pattern, never the last value
   assign d   = q_oe ? q : (drv ? d_val : junk);

   initial begin
      k = 1'b0;
      k_n = 1'b1;
      cmd_n = 1'b1;
      rw = 1'b0;
      a = '0;
      mask_n = 4'hF;
      drv = 1'b0;
      d_val = '0;
      junk = 36'h5A5A5A5A5;
   end

   always @(posedge core_clk) begin
      junk <= ~junk + 36'h1;
   end

   // One input clock period; results sampled at the end of each half
   task automatic cyc(input logic cm, input logic sel,
                      input logic [ADDR_W-1:0] ad, input logic wd,
                      input ddrp_pkg::ddrp_word_t dk,
                      input ddrp_pkg::ddrp_mask_t mk,
                      input ddrp_pkg::ddrp_word_t dkn,
                      input ddrp_pkg::ddrp_mask_t mkn);
      @(posedge core_clk);
      #1;
      k = 1'b1;
      k_n = 1'b0;
      cmd_n = cm;
      rw = sel;
      a = ad;
      drv = wd;
      d_val = dk;
      mask_n = mk;
      repeat (HALF - 1) @(posedge core_clk);
      #1;
      q_k = q;
      oe_k = q_oe;
      @(posedge core_clk);
      #1;
      k = 1'b0;
      k_n = 1'b1;
      d_val = dkn;
      mask_n = mkn;
      repeat (HALF - 1) @(posedge core_clk);
      #1;
      q_kn = q;
      oe_kn = q_oe;
   endtask

   // Input clock parked high on a no-operation, then held while pins wander
   task automatic stall(input int n);
      ddrp_pkg::ddrp_word_t q0;
      logic                 oe0;
      @(posedge core_clk);
      #1;
      k = 1'b1;
      repeat (HALF - 1) @(posedge core_clk);
      #1;
      q0 = q;
      oe0 = q_oe;
      moved = 1'b0;
      for (int i = 0; i < n; i++) begin
         @(posedge core_clk);
         #1;
         if (i % 4 == 0) begin
            cmd_n = ~cmd_n;
            rw = ~rw;
         end
         if (q !== q0 || q_oe !== oe0) moved = 1'b1;
      end
      @(posedge core_clk);
      #1;
      cmd_n = 1'b1;
      rw = 1'b0;
   endtask
endmodule

// ---- ddrp_fifo.sv ----
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`include "ddrp_map.svh"

module ddrp_fifo #(
   parameter int WIDTH = `DDRP_PAIR_W,
   parameter int DEPTH = `DDRP_FIFO_DEPTH
) (
   input  wire logic             core_clk,
   input  wire logic             sys_rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin : g_bad_cfg
      $error("ddrp_fifo: DEPTH must be a power of two >= 2");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0]               wr;
      logic [PW-1:0]               rd;
      logic [PW:0]                 cnt;
   } ddrp_fifo_st_t;

   ddrp_fifo_st_t st;
   ddrp_fifo_st_t next_st;
   logic          push;
   logic          pop;

   assign in_ready  = (st.cnt != (PW+1)'(DEPTH));
   assign out_valid = (st.cnt != '0);
   assign out_data  = st.mem[st.rd];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      next_st = st;
      if (push) begin
         next_st.mem[st.wr] = in_data;
         next_st.wr         = st.wr + 1'b1;
      end
      if (pop) begin
         next_st.rd = st.rd + 1'b1;
      end
      if (push && !pop) begin
         next_st.cnt = st.cnt + 1'b1;
      end else if (pop && !push) begin
         next_st.cnt = st.cnt - 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
endmodule

// ---- ddrp_map.svh ----
// Constants for the double-data-rate burst-of-two SRAM port
`ifndef DDRP_MAP_SVH
`define DDRP_MAP_SVH

// ----------------------------------------------------------------------
// Word and lane layout
// ----------------------------------------------------------------------
`define DDRP_WORD_W     36
`define DDRP_LANES      4
`define DDRP_LANE_W     9
`define DDRP_PAIR_W     72

// ----------------------------------------------------------------------
// Sizing defaults and power-on strap wait count
// ----------------------------------------------------------------------
`define DDRP_ADDR_W_DEF 4
`define DDRP_FIFO_DEPTH 32
`define DDRP_STRAP_WAIT 2'h3

`endif

// ---- ddrp_pkg.sv ----
// Types shared by the SRAM port, its controller model and its testbench
`include "ddrp_map.svh"

package ddrp_pkg;

   typedef logic [`DDRP_WORD_W-1:0] ddrp_word_t;
   typedef logic [`DDRP_LANES-1:0]  ddrp_mask_t;
   typedef logic [`DDRP_PAIR_W-1:0] ddrp_pair_t;

   // Command and data pins as one sampled bundle
   typedef struct packed {
      logic       cmd_n;
      logic       rw;
      ddrp_mask_t mask_n;
      ddrp_word_t data;
   } ddrp_pins_t;

   // Held last word of a write, not yet in the array
   typedef struct packed {
      logic       valid;
      ddrp_mask_t mask_n;
      ddrp_word_t data;
   } ddrp_post_t;

endpackage

// ---- ddrp_port.sv ----
// Command, write and read data path of the burst-of-two SRAM port
`timescale 1ns/1ps
`include "ddrp_map.svh"

module ddrp_port #(
   parameter int ADDR_W     = `DDRP_ADDR_W_DEF,
   parameter int FIFO_DEPTH = `DDRP_FIFO_DEPTH
) (
   input  wire logic                core_clk,
   input  wire logic                sys_rst,
   input  wire logic                in_timing_ref,
   input  wire logic                in_timing_ref_n,
   input  wire logic                out_timing_ref,
   input  wire logic                out_timing_ref_n,
   input  wire logic                cmd_strobe_n,
   input  wire logic                rd_wr_sel,
   input  wire logic [ADDR_W-1:0]   addr,
   input  wire ddrp_pkg::ddrp_mask_t lane_mask_n,
   input  wire ddrp_pkg::ddrp_word_t io_word_in,
   output ddrp_pkg::ddrp_word_t     io_word_out,
   output logic                     io_word_oe
);
   localparam int WORDS = 1 << ADDR_W;

   if (ADDR_W < 1 || ADDR_W > 12) begin : g_bad_addr_w
      $error("ddrp_port: ADDR_W must lie in 1..12");
   end

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef logic [WORDS-1:0][`DDRP_WORD_W-1:0] ddrp_mem_t;

   typedef struct packed {
      logic [2:0]          k_sync;
      logic [2:0]          kn_sync;
      logic [2:0]          c_sync;
      logic [2:0]          cn_sync;
      ddrp_pkg::ddrp_pins_t pin_s1;
      ddrp_pkg::ddrp_pins_t pin_s2;
      logic [ADDR_W-1:0]   addr_s1;
      logic [ADDR_W-1:0]   addr_s2;
      logic [1:0]          strap_cnt;
      logic                strap_done;
      logic                single;
      logic                wr1;
      logic                wr2;
      logic [ADDR_W-1:0]   waddr;
      ddrp_pkg::ddrp_post_t post;
      logic [ADDR_W-1:0]   post_addr;
      logic                stage_valid;
      logic [ADDR_W-1:0]   stage_addr;
      logic                half;
      ddrp_pkg::ddrp_word_t dout;
      logic                oe;
      ddrp_mem_t           mem;
   } ddrp_state_t;

   ddrp_state_t          st;
   ddrp_state_t          next_st;

   logic                 k_rise;
   logic                 kn_rise;
   logic                 o_rise;
   logic                 on_rise;
   logic                 cmd_wr;
   logic                 cmd_rd;
   logic                 rd_ok;
   logic                 push;
   logic                 fifo_in_ready;
   logic                 fifo_out_valid;
   logic                 fifo_out_ready;
   ddrp_pkg::ddrp_pair_t fifo_out_data;
   ddrp_pkg::ddrp_pair_t push_pair;

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   function automatic ddrp_pkg::ddrp_word_t merge(
      input ddrp_pkg::ddrp_word_t old_w,
      input ddrp_pkg::ddrp_word_t new_w,
      input ddrp_pkg::ddrp_mask_t mask_n
   );
      ddrp_pkg::ddrp_word_t r;
      r = old_w;
      for (int i = 0; i < `DDRP_LANES; i++) begin
         if (!mask_n[i]) begin
            r[i*`DDRP_LANE_W +: `DDRP_LANE_W] =
               new_w[i*`DDRP_LANE_W +: `DDRP_LANE_W];
         end
      end
      return r;
   endfunction

   function automatic logic [ADDR_W-1:0] burst_next(
      input logic [ADDR_W-1:0] a
   );
      logic [ADDR_W-1:0] r;
      r = a;
      r[0] = ~a[0];
      return r;
   endfunction

   // Array word with any held write laid over it
   function automatic ddrp_pkg::ddrp_word_t fetch(
      input ddrp_mem_t            m,
      input ddrp_pkg::ddrp_post_t p,
      input logic [ADDR_W-1:0]    pa,
      input logic [ADDR_W-1:0]    a
   );
      if (p.valid && pa == a) begin
         return merge(m[a], p.data, p.mask_n);
      end
      return m[a];
   endfunction

   // ----------------------------------------------------------------------
   // Edge detection on synchronised pins
   // ----------------------------------------------------------------------
   // Clock pins ride the same two-stage path as data, keeping them aligned
   // Sync stages reset low, so an idle-high pin would fake an edge
   assign k_rise  = st.strap_done && st.k_sync[1] && !st.k_sync[2];
   assign kn_rise = st.strap_done && st.kn_sync[1] && !st.kn_sync[2];
   assign o_rise  = st.single ? k_rise
                              : (st.strap_done && st.c_sync[1]
                                 && !st.c_sync[2]);
   assign on_rise = st.single ? kn_rise
                              : (st.strap_done && st.cn_sync[1]
                                 && !st.cn_sync[2]);
   assign cmd_wr  = k_rise && !st.pin_s2.cmd_n && !st.pin_s2.rw;
   assign cmd_rd  = k_rise && !st.pin_s2.cmd_n && st.pin_s2.rw;
   // Read refused only when the buffer stays full; cannot happen at spec rate
   assign rd_ok   = !(st.stage_valid && !fifo_in_ready);
   assign push    = k_rise && st.stage_valid;
   // Fetched at push, after word two of a write just before is held
   assign push_pair = {fetch(st.mem, st.post, st.post_addr,
                             burst_next(st.stage_addr)),
                       fetch(st.mem, st.post, st.post_addr,
                             st.stage_addr)};
   assign fifo_out_ready = o_rise && st.half;

   assign io_word_out = st.dout;
   assign io_word_oe  = st.oe;

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      next_st         = st;
      next_st.k_sync  = {st.k_sync[1:0], in_timing_ref};
      next_st.kn_sync = {st.kn_sync[1:0], in_timing_ref_n};
      next_st.c_sync  = {st.c_sync[1:0], out_timing_ref};
      next_st.cn_sync = {st.cn_sync[1:0], out_timing_ref_n};
      next_st.pin_s1  = '{cmd_n: cmd_strobe_n, rw: rd_wr_sel,
                          mask_n: lane_mask_n, data: io_word_in};
      next_st.pin_s2  = st.pin_s1;
      next_st.addr_s1 = addr;
      next_st.addr_s2 = st.addr_s1;

      // Strap read once the synchronisers hold real pin levels
      if (!st.strap_done) begin
         if (st.strap_cnt == `DDRP_STRAP_WAIT) begin
            next_st.single     = st.c_sync[1] && st.cn_sync[1];
            next_st.strap_done = 1'b1;
         end else begin
            next_st.strap_cnt = st.strap_cnt + 2'h1;
         end
      end

      if (k_rise) begin
         if (push && fifo_in_ready) begin
            next_st.stage_valid = 1'b0;
         end
         // Older held word goes in first so a newer word one wins
         if (cmd_wr && st.post.valid) begin
            next_st.mem[st.post_addr] = merge(st.mem[st.post_addr],
               st.post.data, st.post.mask_n);
            next_st.post.valid = 1'b0;
         end
         if (st.wr1) begin
            next_st.mem[st.waddr] = merge(next_st.mem[st.waddr],
               st.pin_s2.data, st.pin_s2.mask_n);
            next_st.wr1 = 1'b0;
            next_st.wr2 = 1'b1;
         end
         if (cmd_wr) begin
            next_st.wr1   = 1'b1;
            next_st.waddr = st.addr_s2;
         end else if (cmd_rd && rd_ok) begin
            next_st.stage_valid = 1'b1;
            next_st.stage_addr  = st.addr_s2;
         end
      end

      if (kn_rise && st.wr2) begin
         next_st.post.valid  = 1'b1;
         next_st.post.data   = st.pin_s2.data;
         next_st.post.mask_n = st.pin_s2.mask_n;
         next_st.post_addr   = burst_next(st.waddr);
         next_st.wr2         = 1'b0;
      end

      // Output launch; without edges nothing moves, so pins hold
      if (on_rise && fifo_out_valid && !st.half) begin
         next_st.dout = fifo_out_data[`DDRP_WORD_W-1:0];
         next_st.oe   = 1'b1;
         next_st.half = 1'b1;
      end else if (o_rise) begin
         if (st.half) begin
            next_st.dout = fifo_out_data[`DDRP_PAIR_W-1:`DDRP_WORD_W];
            next_st.half = 1'b0;
         end else begin
            next_st.oe = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------------
   // Read pair buffer
   // ----------------------------------------------------------------------
   ddrp_fifo #(
      .WIDTH (`DDRP_PAIR_W),
      .DEPTH (FIFO_DEPTH)
   ) u_rd_fifo (
      .core_clk  (core_clk),
      .sys_rst   (sys_rst),
      .in_valid  (push),
      .in_ready  (fifo_in_ready),
      .in_data   (push_pair),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
   );

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   sequence s_launch1;
      on_rise && fifo_out_valid && !st.half;
   endsequence

   sequence s_launch2;
      o_rise && st.half;
   endsequence

   a_reset_hiz: assert property ($fell(sys_rst) |-> !io_word_oe)
      else $error("data pins driven right after reset");

   a_nop_idle: assert property (
      k_rise && st.pin_s2.cmd_n && !st.wr1 |=> $stable(st.mem))
      else $error("array changed on a no-operation edge");

   a_full_word: assert property (
      k_rise && st.wr1 && st.pin_s2.mask_n == '0
      |=> st.mem[$past(st.waddr)] == $past(st.pin_s2.data))
      else $error("full-mask write did not store the word");

   a_lane_hold: assert property (
      k_rise && st.wr1 && st.pin_s2.mask_n[0] && !cmd_wr
      |=> st.mem[$past(st.waddr)][8:0] ==
          $past(st.mem[st.waddr][8:0]))
      else $error("masked lane zero was altered");

   a_mask_none: assert property (
      k_rise && st.wr1 && (&st.pin_s2.mask_n) && !cmd_wr
      |=> $stable(st.mem))
      else $error("all-high mask changed the array");

   a_burst_addr: assert property (
      kn_rise && st.wr2
      |=> (st.post_addr ^ $past(st.waddr)) == ADDR_W'(1)
          && st.post.valid
          && st.post.mask_n == $past(st.pin_s2.mask_n))
      else $error("second word address or mask wrong");

   a_post_hold: assert property (
      st.post.valid && !cmd_wr |=> st.post.valid)
      else $error("held write lost before next write");

   a_word_order: assert property (
      s_launch2 |=> io_word_oe
          && io_word_out == $past(fifo_out_data[71:36]))
      else $error("second read word wrong");

   a_first_word: assert property (
      s_launch1 |=> io_word_oe
         && io_word_out == $past(fifo_out_data[35:0]))
      else $error("first read word not launched");

   a_stop_hold: assert property (
      !o_rise && !on_rise |=> $stable(io_word_out)
         && $stable(io_word_oe))
      else $error("pins moved without an output clock edge");

   a_strap_fixed: assert property (
      st.strap_done |=> st.strap_done && $stable(st.single))
      else $error("clock mode changed after power-on");
endmodule

// ---- ddrp_port_test.sv ----
// Self-checking testbench for the burst-of-two SRAM port
`timescale 1ns/1ps
`include "ddrp_map.svh"

module ddrp_port_test;
   logic                 core_clk;
   logic                 sys_rst;
   logic                 single_mode;
   logic                 k, k_n, c, c_n, cmd_n, rw, q_oe;
   logic [3:0]           a;
   ddrp_pkg::ddrp_mask_t mask_n;
   ddrp_pkg::ddrp_word_t d;
   ddrp_pkg::ddrp_word_t q;
   ddrp_pkg::ddrp_word_t exp_mem [16];
   int                   fails;
   int                   checks;

   always #2.5 core_clk = ~core_clk;

   ddrp_port #(.ADDR_W(4), .FIFO_DEPTH(32)) dut_u (
      .core_clk(core_clk), .sys_rst(sys_rst), .in_timing_ref(k),
      .in_timing_ref_n(k_n), .out_timing_ref(c), .out_timing_ref_n(c_n),
      .cmd_strobe_n(cmd_n), .rd_wr_sel(rw), .addr(a),
      .lane_mask_n(mask_n), .io_word_in(d), .io_word_out(q),
      .io_word_oe(q_oe));

   ddrp_ctl_model #(.ADDR_W(4), .HALF(6)) ctl_u (
      .core_clk(core_clk), .single_mode(single_mode), .k(k), .k_n(k_n),
      .c(c), .c_n(c_n), .cmd_n(cmd_n), .rw(rw), .a(a), .mask_n(mask_n),
      .d(d), .q(q), .q_oe(q_oe));

   task automatic conclude();
      $display("Checks %0d, mismatches %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input ddrp_pkg::ddrp_word_t got,
                      input ddrp_pkg::ddrp_word_t want);
      checks++;
      if (got !== want) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, want);
      end
   endtask

   function automatic ddrp_pkg::ddrp_word_t merge(
      input ddrp_pkg::ddrp_word_t o, input ddrp_pkg::ddrp_word_t n,
      input ddrp_pkg::ddrp_mask_t m);
      ddrp_pkg::ddrp_word_t r;
      r = o;
      for (int i = 0; i < `DDRP_LANES; i++)
         if (!m[i]) r[i*`DDRP_LANE_W +: `DDRP_LANE_W] =
            n[i*`DDRP_LANE_W +: `DDRP_LANE_W];
      return r;
   endfunction

   task automatic do_reset(input logic sgl);
      single_mode = sgl;
      sys_rst = 1'b1;
      repeat (12) @(posedge core_clk);
      #1;
      sys_rst = 1'b0;
      for (int i = 0; i < 16; i++) exp_mem[i] = '0;
      // Strap is taken a few edges after release
      repeat (6) @(posedge core_clk);
   endtask

   task automatic nop(input logic sel);
      ctl_u.cyc(1'b1, sel, '0, 1'b0, '0, 4'hF, '0, 4'hF);
   endtask

   task automatic wr(input logic [3:0] ad, input ddrp_pkg::ddrp_word_t w1,
                     input ddrp_pkg::ddrp_mask_t m1,
                     input ddrp_pkg::ddrp_word_t w2,
                     input ddrp_pkg::ddrp_mask_t m2);
      ctl_u.cyc(1'b0, 1'b0, ad, 1'b0, '0, 4'hF, '0, 4'hF);
      ctl_u.cyc(1'b1, 1'b0, '0, 1'b1, w1, m1, w2, m2);
      exp_mem[ad] = merge(exp_mem[ad], w1, m1);
      exp_mem[ad ^ 4'h1] = merge(exp_mem[ad ^ 4'h1], w2, m2);
   endtask

   // Read burst; a hold count stops the input clock, parked high, while word two is out
   task automatic rd(input logic [3:0] ad, input int hold);
      ctl_u.cyc(1'b0, 1'b1, ad, 1'b0, '0, 4'hF, '0, 4'hF);
      nop(1'b0);
      chk(ctl_u.q_kn, exp_mem[ad]);
      chk(36'(ctl_u.oe_kn), 36'h1);
      if (hold > 0) begin
         ctl_u.stall(hold);
         chk(36'(ctl_u.moved), 36'h0);
      end
      nop(1'b0);
      chk(ctl_u.q_k, exp_mem[ad ^ 4'h1]);
   endtask

   task automatic s_idle();
      chk(36'(q_oe), 36'h0);
      nop(1'b1);
      nop(1'b0);
      chk(36'(ctl_u.oe_k | ctl_u.oe_kn), 36'h0);
   endtask

   task automatic s_burst();
      wr(4'h5, 36'h123456789, 4'h0, 36'hFEDCBA987, 4'h0);
      rd(4'h4, 0);
      rd(4'h5, 0);
      wr(4'h2, 36'h0F0F0F0F0, 4'h0, 36'h3C3C3C3C3, 4'h0);
      wr(4'h3, 36'hAAAAAAAAA, 4'h0, 36'h555555555, 4'h0);
      rd(4'h2, 0);
   endtask

   task automatic s_lanes();
      ddrp_pkg::ddrp_mask_t m;
      ddrp_pkg::ddrp_word_t w;
      wr(4'h8, 36'h111111111, 4'h0, 36'h222222222, 4'h0);
      for (int i = 0; i < 4; i++) begin
         m = ~(4'h1 << i);
         w = {4{9'(i * 37 + 9'h0A5)}};
         wr(4'h8, w, m, ~w, i[0] ? 4'hF : ~m);
         rd(4'h8, 0);
      end
   endtask

   // Read issued straight after a write of the same address
   task automatic s_fwd();
      ctl_u.cyc(1'b0, 1'b0, 4'h9, 1'b0, '0, 4'hF, '0, 4'hF);
      ctl_u.cyc(1'b0, 1'b1, 4'h9, 1'b1, 36'h0A0B0C0D0, 4'hF,
                36'h1E2D3C4B5, 4'h5);
      exp_mem[4'h8] = merge(exp_mem[4'h8], 36'h1E2D3C4B5, 4'h5);
      nop(1'b0);
      chk(ctl_u.q_kn, exp_mem[4'h9]);
      nop(1'b0);
      chk(ctl_u.q_k, exp_mem[4'h8]);
   endtask

   task automatic s_stop();
      wr(4'hC, 36'h0CAFEBABE, 4'h0, 36'h0DEADBEEF, 4'h0);
      rd(4'hC, 40);
   endtask

   task automatic s_single();
      do_reset(1'b1);
      chk(36'(q_oe), 36'h0);
      rd(4'hA, 0);
      wr(4'h6, 36'h13579BDF1, 4'h0, 36'h2468ACE02, 4'h0);
      nop(1'b0);
      rd(4'h6, 0);
   endtask

   initial begin
      core_clk = 1'b0;
      sys_rst = 1'b1;
      single_mode = 1'b0;
      fails = 0;
      checks = 0;
      do_reset(1'b0);
      s_idle();
      s_burst();
      s_lanes();
      s_fwd();
      s_stop();
      s_single();
      conclude();
   end

   // Guard against a hung run
   initial begin
      repeat (100000) @(posedge core_clk);
      fails++;
      conclude();
   end
endmodule
